// [hdl/cbr_regs.svh]
// Behaviour
// - thirteen architectural registers visible, banked ones counted once
// - two copies of banked set; bank select bit picks copy 0 or 1
// - data words 0 and 1 have separately addressable high and low bytes
// - data word 2 over 0 and 3 over 1 form 32-bit operands
// - address words form 32-bit operand, word 1 above word 0
// - frame base is 16 bits, base for frame-relative addressing
// - vector table base is 20 bits, start of relocatable vector table
// - program counter is 20 bits, address of next instruction
// - two 16-bit stack pointers; stack select flag picks the active one
// - static base is 16 bits, base for static-relative addressing
// - flag word is 11 bits wide
// - carry flag captures carry, borrow or shifted-out bit of each operation
// - zero flag set when result is zero, cleared otherwise
// - sign flag set when result is negative, cleared otherwise
// - overflow flag set when operation overflows, cleared otherwise
// - decode one-megabyte address space 00000h to FFFFFh
// - program ROM ends at 0FFFFh and extends downward by its size
// - fixed vector table occupies 0FFDCh to 0FFFFh
// - data flash decoded at 02400h to 02BFFh
// - RAM starts at 00400h and extends upward by its size
// - peripheral registers at 00000h to 002FFh; unassigned parts reserved
`ifndef CBR_REGS_SVH
`define CBR_REGS_SVH
`define CBR_OFF_DW0 12'h000
`define CBR_OFF_DW1 12'h004
`define CBR_OFF_DW2 12'h008
`define CBR_OFF_DW3 12'h00c
`define CBR_OFF_AW0 12'h010
`define CBR_OFF_AW1 12'h014
`define CBR_OFF_FB 12'h018
`define CBR_OFF_VTB 12'h01c
`define CBR_OFF_PC 12'h020
`define CBR_OFF_USP 12'h024
`define CBR_OFF_ISP 12'h028
`define CBR_OFF_SB 12'h02c
`define CBR_OFF_FLG 12'h030
`define CBR_OFF_DW0_LO 12'h040
`define CBR_OFF_DW0_HI 12'h044
`define CBR_OFF_DW1_LO 12'h048
`define CBR_OFF_DW1_HI 12'h04c
`define CBR_OFF_LONG_LO 12'h050
`define CBR_OFF_LONG_HI 12'h054
`define CBR_OFF_ADDR_LONG 12'h058
`define CBR_OFF_ACT_SP 12'h05c
`define CBR_OFF_ALU_CMD 12'h060
`define CBR_OFF_DECODE 12'h064
`define CBR_FLG_CARRY 0
`define CBR_FLG_TRACE 1
`define CBR_FLG_ZERO 2
`define CBR_FLG_SIGN 3
`define CBR_FLG_BANK 4
`define CBR_FLG_OVF 5
`define CBR_FLG_STACK 7
`define CBR_FLG_RESET 11'h000
`define CBR_PC_RESET 20'h00000
`define CBR_SFR_END 20'h002ff
`define CBR_RAM_BASE 20'h00400
`define CBR_FLASH_BASE 20'h02400
`define CBR_FLASH_END 20'h02bff
`define CBR_ROM_END 20'h0ffff
`define CBR_VEC_BASE 20'h0ffdc
`define CBR_RAM_SIZE_DEF 20'h00400
`define CBR_ROM_SIZE_DEF 20'h04000
`endif

// [hdl/cbr_pkg.sv]
package cbr_pkg;
    typedef enum logic [2:0] {
        CBR_OP_ADD = 3'h0,
        CBR_OP_SUB = 3'h1,
        CBR_OP_AND = 3'h2,
        CBR_OP_OR = 3'h3,
        CBR_OP_XOR = 3'h4,
        CBR_OP_SHL = 3'h5,
        CBR_OP_SHR = 3'h6,
        CBR_OP_PASS = 3'h7
    } cbr_op_e;

    typedef enum logic [2:0] {
        CBR_REG_SFR = 3'h0,
        CBR_REG_RAM = 3'h1,
        CBR_REG_FLASH = 3'h2,
        CBR_REG_ROM = 3'h3,
        CBR_REG_VECTOR = 3'h4,
        CBR_REG_RESERVED = 3'h5
    } cbr_region_e;

    typedef struct packed {
        logic [15:0] dw0;
        logic [15:0] dw1;
        logic [15:0] dw2;
        logic [15:0] dw3;
        logic [15:0] aw0;
        logic [15:0] aw1;
        logic [15:0] fb;
    } cbr_bank_s;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } cbr_apb_req_s;
endpackage

// [hdl/cbr_core_regs.sv]
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "cbr_regs.svh"
module cbr_core_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core view
    output logic [15:0] active_sp,
    output logic [19:0] program_counter,
    output logic [19:0] vector_table_base,
    output logic [10:0] flag_word,
    output cbr_pkg::cbr_region_e decode_region
);
    cbr_pkg::cbr_bank_s bank_r [2];
    cbr_pkg::cbr_bank_s bank_nxt [2];
    cbr_pkg::cbr_apb_req_s req;
    logic [19:0] vtb_r, vtb_nxt, pc_r, pc_nxt;
    logic [15:0] usp_r, usp_nxt, isp_r, isp_nxt, sb_r, sb_nxt;
    logic [10:0] flg_r, flg_nxt;
    logic [19:0] dec_addr_r, dec_addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;
    logic wait_r, wait_nxt;
    logic wr, rd, hit;
    logic [31:0] rd_mux;
    logic sel_bank;
    cbr_pkg::cbr_bank_s cur;
    cbr_pkg::cbr_region_e region;
    // alu operands
    logic [2:0] alu_op;
    logic alu_wide;
    logic [31:0] alu_a, alu_b, alu_res;
    logic [32:0] alu_ext;
    logic alu_c, alu_v, alu_neg;

    assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite,
                   pwdata: pwdata};
    // writes land only in the answering cycle, so an alu command runs once
    assign wr = req.psel && req.penable && req.pwrite && wait_r;
    assign rd = req.psel && req.penable && !req.pwrite;
    assign sel_bank = flg_r[`CBR_FLG_BANK];
    assign cur = bank_r[sel_bank];

    // address decode over the whole 1 MB space
    always_comb begin
        if (dec_addr_r <= `CBR_SFR_END) begin
            region = cbr_pkg::CBR_REG_SFR;
        end else if (dec_addr_r >= `CBR_RAM_BASE &&
                     dec_addr_r < `CBR_RAM_BASE + `CBR_RAM_SIZE_DEF) begin
            region = cbr_pkg::CBR_REG_RAM;
        end else if (dec_addr_r >= `CBR_FLASH_BASE && dec_addr_r <= `CBR_FLASH_END) begin
            region = cbr_pkg::CBR_REG_FLASH;
        end else if (dec_addr_r >= `CBR_VEC_BASE && dec_addr_r <= `CBR_ROM_END) begin
            region = cbr_pkg::CBR_REG_VECTOR;
        end else if (dec_addr_r > `CBR_ROM_END - `CBR_ROM_SIZE_DEF &&
                     dec_addr_r <= `CBR_ROM_END) begin
            region = cbr_pkg::CBR_REG_ROM;
        end else begin
            region = cbr_pkg::CBR_REG_RESERVED;
        end
    end

    // alu: low 3 bits op, bit 3 selects 32-bit pair operands
    assign alu_op = pwdata[2:0];
    assign alu_wide = pwdata[3];
    always_comb begin
        if (alu_wide) begin
            alu_a = {cur.dw2, cur.dw0};
            alu_b = {cur.dw3, cur.dw1};
        end else begin
            alu_a = {16'h0000, cur.dw0};
            alu_b = {16'h0000, cur.dw1};
        end
        alu_ext = {1'b0, alu_a};
        alu_v = 1'b0;
        unique case (cbr_pkg::cbr_op_e'(alu_op))
            cbr_pkg::CBR_OP_ADD: alu_ext = {1'b0, alu_a} + {1'b0, alu_b};
            cbr_pkg::CBR_OP_SUB: alu_ext = {1'b0, alu_a} - {1'b0, alu_b};
            cbr_pkg::CBR_OP_AND: alu_ext = {1'b0, alu_a & alu_b};
            cbr_pkg::CBR_OP_OR: alu_ext = {1'b0, alu_a | alu_b};
            cbr_pkg::CBR_OP_XOR: alu_ext = {1'b0, alu_a ^ alu_b};
            cbr_pkg::CBR_OP_SHL: alu_ext = {alu_a, 1'b0};
            cbr_pkg::CBR_OP_SHR: alu_ext = {alu_a[0], 1'b0, alu_a[31:1]};
            cbr_pkg::CBR_OP_PASS: alu_ext = {1'b0, alu_a};
        endcase
        if (!alu_wide) begin
            alu_res = {16'h0000, alu_ext[15:0]};
            alu_neg = alu_ext[15];
            if (alu_op == 3'h1) begin
                alu_c = alu_a[15:0] < alu_b[15:0];
            end else if (alu_op == 3'h5) begin
                alu_c = alu_a[15];
            end else if (alu_op == 3'h6) begin
                alu_c = alu_a[0];
            end else begin
                alu_c = alu_ext[16];
            end
            if (alu_op == 3'h0) begin
                alu_v = (alu_a[15] == alu_b[15]) && (alu_ext[15] != alu_a[15]);
            end else if (alu_op == 3'h1) begin
                alu_v = (alu_a[15] != alu_b[15]) && (alu_ext[15] != alu_a[15]);
            end
        end else begin
            alu_res = alu_ext[31:0];
            alu_neg = alu_ext[31];
            alu_c = (alu_op == 3'h6) ? alu_ext[32] : alu_ext[32];
            if (alu_op == 3'h0) begin
                alu_v = (alu_a[31] == alu_b[31]) && (alu_ext[31] != alu_a[31]);
            end else if (alu_op == 3'h1) begin
                alu_v = (alu_a[31] != alu_b[31]) && (alu_ext[31] != alu_a[31]);
            end
        end
    end

    // read mux over the visible set
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (req.paddr)
            `CBR_OFF_DW0: rd_mux = {16'h0000, cur.dw0};
            `CBR_OFF_DW1: rd_mux = {16'h0000, cur.dw1};
            `CBR_OFF_DW2: rd_mux = {16'h0000, cur.dw2};
            `CBR_OFF_DW3: rd_mux = {16'h0000, cur.dw3};
            `CBR_OFF_AW0: rd_mux = {16'h0000, cur.aw0};
            `CBR_OFF_AW1: rd_mux = {16'h0000, cur.aw1};
            `CBR_OFF_FB: rd_mux = {16'h0000, cur.fb};
            `CBR_OFF_VTB: rd_mux = {12'h000, vtb_r};
            `CBR_OFF_PC: rd_mux = {12'h000, pc_r};
            `CBR_OFF_USP: rd_mux = {16'h0000, usp_r};
            `CBR_OFF_ISP: rd_mux = {16'h0000, isp_r};
            `CBR_OFF_SB: rd_mux = {16'h0000, sb_r};
            `CBR_OFF_FLG: rd_mux = {21'h000000, flg_r};
            `CBR_OFF_DW0_LO: rd_mux = {24'h000000, cur.dw0[7:0]};
            `CBR_OFF_DW0_HI: rd_mux = {24'h000000, cur.dw0[15:8]};
            `CBR_OFF_DW1_LO: rd_mux = {24'h000000, cur.dw1[7:0]};
            `CBR_OFF_DW1_HI: rd_mux = {24'h000000, cur.dw1[15:8]};
            `CBR_OFF_LONG_LO: rd_mux = {cur.dw2, cur.dw0};
            `CBR_OFF_LONG_HI: rd_mux = {cur.dw3, cur.dw1};
            `CBR_OFF_ADDR_LONG: rd_mux = {cur.aw1, cur.aw0};
            `CBR_OFF_ACT_SP: rd_mux = {16'h0000, active_sp};
            `CBR_OFF_ALU_CMD: rd_mux = alu_res;
            `CBR_OFF_DECODE: rd_mux = {9'h000, region, dec_addr_r};
            default: hit = 1'b0;
        endcase
    end

    // next-state for the whole register set
    always_comb begin
        bank_nxt = bank_r;
        vtb_nxt = vtb_r;
        pc_nxt = pc_r;
        usp_nxt = usp_r;
        isp_nxt = isp_r;
        sb_nxt = sb_r;
        flg_nxt = flg_r;
        dec_addr_nxt = dec_addr_r;
        rdata_nxt = rdata_r;
        err_nxt = 1'b0;
        if (req.psel && req.penable) begin
            // writes and refused reads return zero
            rdata_nxt = (rd && hit) ? rd_mux : 32'h0000_0000;
            err_nxt = !hit;
        end
        if (wr) begin
            unique case (req.paddr)
                `CBR_OFF_DW0: bank_nxt[sel_bank].dw0 = req.pwdata[15:0];
                `CBR_OFF_DW1: bank_nxt[sel_bank].dw1 = req.pwdata[15:0];
                `CBR_OFF_DW2: bank_nxt[sel_bank].dw2 = req.pwdata[15:0];
                `CBR_OFF_DW3: bank_nxt[sel_bank].dw3 = req.pwdata[15:0];
                `CBR_OFF_AW0: bank_nxt[sel_bank].aw0 = req.pwdata[15:0];
                `CBR_OFF_AW1: bank_nxt[sel_bank].aw1 = req.pwdata[15:0];
                `CBR_OFF_FB: bank_nxt[sel_bank].fb = req.pwdata[15:0];
                `CBR_OFF_VTB: vtb_nxt = req.pwdata[19:0];
                `CBR_OFF_PC: pc_nxt = req.pwdata[19:0];
                `CBR_OFF_USP: usp_nxt = req.pwdata[15:0];
                `CBR_OFF_ISP: isp_nxt = req.pwdata[15:0];
                `CBR_OFF_SB: sb_nxt = req.pwdata[15:0];
                `CBR_OFF_FLG: flg_nxt = req.pwdata[10:0];
                `CBR_OFF_DW0_LO: bank_nxt[sel_bank].dw0[7:0] = req.pwdata[7:0];
                `CBR_OFF_DW0_HI: bank_nxt[sel_bank].dw0[15:8] = req.pwdata[7:0];
                `CBR_OFF_DW1_LO: bank_nxt[sel_bank].dw1[7:0] = req.pwdata[7:0];
                `CBR_OFF_DW1_HI: bank_nxt[sel_bank].dw1[15:8] = req.pwdata[7:0];
                `CBR_OFF_LONG_LO: begin
                    bank_nxt[sel_bank].dw0 = req.pwdata[15:0];
                    bank_nxt[sel_bank].dw2 = req.pwdata[31:16];
                end
                `CBR_OFF_LONG_HI: begin
                    bank_nxt[sel_bank].dw1 = req.pwdata[15:0];
                    bank_nxt[sel_bank].dw3 = req.pwdata[31:16];
                end
                `CBR_OFF_ADDR_LONG: begin
                    bank_nxt[sel_bank].aw0 = req.pwdata[15:0];
                    bank_nxt[sel_bank].aw1 = req.pwdata[31:16];
                end
                `CBR_OFF_ACT_SP: begin
                    if (flg_r[`CBR_FLG_STACK]) begin
                        usp_nxt = req.pwdata[15:0];
                    end else begin
                        isp_nxt = req.pwdata[15:0];
                    end
                end
                `CBR_OFF_ALU_CMD: begin
                    // result lands in data word 0 (and 2 for wide ops)
                    bank_nxt[sel_bank].dw0 = alu_res[15:0];
                    if (alu_wide) begin
                        bank_nxt[sel_bank].dw2 = alu_res[31:16];
                    end
                    flg_nxt[`CBR_FLG_CARRY] = alu_c;
                    flg_nxt[`CBR_FLG_ZERO] = (alu_res == 32'h0000_0000);
                    flg_nxt[`CBR_FLG_SIGN] = alu_neg;
                    flg_nxt[`CBR_FLG_OVF] = alu_v;
                end
                `CBR_OFF_DECODE: dec_addr_nxt = req.pwdata[19:0];
                default: ;
            endcase
        end
    end

    // register stage; banks cleared to zero so reads after reset are defined
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bank_r[0] <= '0;
            bank_r[1] <= '0;
            vtb_r <= 20'h00000;
            pc_r <= `CBR_PC_RESET;
            usp_r <= 16'h0000;
            isp_r <= 16'h0000;
            sb_r <= 16'h0000;
            flg_r <= `CBR_FLG_RESET;
            dec_addr_r <= 20'h00000;
            rdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else begin
            bank_r <= bank_nxt;
            vtb_r <= vtb_nxt;
            pc_r <= pc_nxt;
            usp_r <= usp_nxt;
            isp_r <= isp_nxt;
            sb_r <= sb_nxt;
            flg_r <= flg_nxt;
            dec_addr_r <= dec_addr_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
        end
    end

    // answer one cycle after the first access cycle: the wait state buys a flopped prdata
    always_comb begin
        wait_nxt = psel && penable && !wait_r;
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= wait_nxt;
        end
    end

    assign pready = wait_r;
    assign prdata = rdata_r;
    assign pslverr = wait_r && err_r;
    // stack select set means user stack
    assign active_sp = flg_r[`CBR_FLG_STACK] ? usp_r : isp_r;
    assign program_counter = pc_r;
    assign vector_table_base = vtb_r;
    assign flag_word = flg_r;
    assign decode_region = region;
endmodule

// [tb/cbr_core_regs_properties.sv]
`timescale 1ns/1ps
module cbr_core_regs_properties (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // core view
    input wire logic [15:0] active_sp,
    input wire logic [19:0] program_counter,
    input wire logic [19:0] vector_table_base,
    input wire logic [10:0] flag_word,
    input wire cbr_pkg::cbr_region_e decode_region
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic acc, wr, rd, mapped;
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign mapped = paddr[1:0] == 2'h0 &&
        (paddr <= 12'h030 || (paddr >= 12'h040 && paddr <= 12'h064));
    property p_unmapped;
        acc && !mapped |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("access never answered");
    property p_flg_wr;
        wr && paddr == 12'h030 |=> flag_word == $past(pwdata[10:0]);
    endproperty
    a_flg_wr: assert property (p_flg_wr) else $error("flag word write lost");
    property p_flg_rd;
        rd && paddr == 12'h030 |-> prdata == {21'h0, flag_word};
    endproperty
    a_flg_rd: assert property (p_flg_rd) else $error("flag word read wrong");
    property p_flg_hold;
        !(wr && (paddr == 12'h030 || paddr == 12'h060)) |=> $stable(flag_word);
    endproperty
    a_flg_hold: assert property (p_flg_hold) else $error("flags moved without cause");
    property p_pc_wr;
        wr && paddr == 12'h020 |=> program_counter == $past(pwdata[19:0]);
    endproperty
    a_pc_wr: assert property (p_pc_wr) else $error("program counter write lost");
    property p_pc_hold;
        !(wr && paddr == 12'h020) |=> $stable(program_counter);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("program counter moved");
    property p_vtb_wr;
        wr && paddr == 12'h01c |=> vector_table_base == $past(pwdata[19:0]);
    endproperty
    a_vtb_wr: assert property (p_vtb_wr) else $error("vector base write lost");
    property p_usp;
        wr && paddr == 12'h024 && flag_word[7] |=> active_sp == $past(pwdata[15:0]);
    endproperty
    a_usp: assert property (p_usp) else $error("user stack not active");
    property p_isp;
        wr && paddr == 12'h028 && !flag_word[7] |=> active_sp == $past(pwdata[15:0]);
    endproperty
    a_isp: assert property (p_isp) else $error("interrupt stack not active");
    property p_dec_rd;
        rd && paddr == 12'h064 |-> prdata[22:20] == decode_region;
    endproperty
    a_dec_rd: assert property (p_dec_rd) else $error("region read differs");
    c_alu: cover property (wr && paddr == 12'h060);
    c_wide: cover property (wr && paddr == 12'h060 && pwdata[3]);
    c_bank: cover property (wr && paddr == 12'h030 && pwdata[4]);
    c_err: cover property (acc && pslverr);
endmodule
bind cbr_core_regs cbr_core_regs_properties cbr_core_regs_properties_inst (.mclk, .reset,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .active_sp,
    .program_counter, .vector_table_base, .flag_word, .decode_region);

// [tb/tb_cbr_core_regs.sv]
`timescale 1ns/1ps
module tb_cbr_core_regs;
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, d, ef, mk;
    logic [15:0] active_sp, a, b;
    logic [16:0] r;
    logic [32:0] rw;
    logic [19:0] program_counter, vector_table_base;
    logic [10:0] flag_word;
    cbr_pkg::cbr_region_e decode_region;
    int error_cnt = 0, samples_checked = 0, seed = 74881, op;
    // model: banked words per copy, other registers by index
    logic [15:0] bk [2][7];
    logic [31:0] m [13];
    logic [19:0] dec_a [18] = '{20'h00000, 20'h002ff, 20'h00300, 20'h003ff, 20'h00400,
        20'h007ff, 20'h00800, 20'h023ff, 20'h02400, 20'h02bff, 20'h02c00, 20'h0bfff,
        20'h0c000, 20'h0ffdb, 20'h0ffdc, 20'h0ffff, 20'h10000, 20'hfffff};
    logic [2:0] dec_r [18] = '{3'h0, 3'h0, 3'h5, 3'h5, 3'h1, 3'h1, 3'h5, 3'h5, 3'h2, 3'h2,
        3'h5, 3'h5, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
    logic [11:0] bad [4] = '{12'h034, 12'h03c, 12'h068, 12'hffc};
    cbr_core_regs cbr_core_regs_inst (.mclk, .reset, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .active_sp, .program_counter,
        .vector_table_base, .flag_word, .decode_region);
    initial begin
        forever #50 mclk = ~mclk;
    end
    function automatic logic [31:0] get(input int i);
        return i < 7 ? {16'h0, bk[m[12][4]][i]} : m[i];
    endfunction
    function automatic logic [31:0] view(input int k);
        logic [15:0] w [7];
        w = bk[m[12][4]];
        case (k)
            0, 2: return {24'h0, w[k / 2][7:0]};
            1, 3: return {24'h0, w[k / 2][15:8]};
            4: return {w[2], w[0]};
            5: return {w[3], w[1]};
            default: return {w[5], w[4]};
        endcase
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", s, e, g);
            error_cnt++;
        end
    endtask
    // waits an edge first so release and the next setup never share a time step
    task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] dt);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        chk("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wreg(input int i, input logic [31:0] dt);
        xfer(1'b1, 12'(i * 4), dt);
        if (i < 7) bk[m[12][4]][i] = dt[15:0];
        else m[i] = dt & ((i == 7 || i == 8) ? 32'hfffff : (i == 12 ? 32'h7ff : 32'hffff));
    endtask
    task automatic rreg(input int i);
        xfer(1'b0, 12'(i * 4), 32'h0);
        chk("reg", get(i), rd);
        chk("ok", 32'h0, {31'h0, err});
    endtask
    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end
    initial begin
        bk = '{default: 16'h0};
        m = '{default: 32'h0};
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 13; i++) rreg(i);
        // trace and bank bits kept clear here; banks are switched on purpose below
        for (int i = 0; i < 13; i++) begin
            d = $random(seed);
            wreg(i, i == 12 ? d & 32'h7ed : d);
        end
        for (int i = 0; i < 13; i++) rreg(i);
        #1;
        chk("pc", m[8], {12'h0, program_counter});
        chk("vtb", m[7], {12'h0, vector_table_base});
        chk("flg", m[12], {21'h0, flag_word});
        for (int k = 0; k < 2; k++) begin
            wreg(12, m[12] ^ 32'h80);
            #1;
            chk("sp", m[12][7] ? m[9] : m[10], {16'h0, active_sp});
            xfer(1'b0, 12'h05c, 32'h0);
            chk("sp_rd", m[12][7] ? m[9] : m[10], rd);
        end
        for (int k = 0; k < 2; k++) begin
            wreg(12, m[12] ^ 32'h10);
            if (k == 0) for (int i = 0; i < 7; i++) wreg(i, $random(seed));
            for (int i = 0; i < 7; i++) rreg(i);
        end
        for (int k = 0; k < 4; k++) begin
            d = $random(seed);
            xfer(1'b1, 12'h040 + 12'(k * 4), d);
            if (k[0]) bk[m[12][4]][k / 2][15:8] = d[7:0];
            else bk[m[12][4]][k / 2][7:0] = d[7:0];
            rreg(k / 2);
        end
        for (int k = 0; k < 7; k++) begin
            xfer(1'b0, 12'h040 + 12'(k * 4), 32'h0);
            chk("view", view(k), rd);
        end
        for (int i = 0; i < 14; i++) begin
            op = i % 8;
            a = 16'($random(seed));
            b = (i == 9) ? a : 16'($random(seed));
            wreg(0, {16'h0, a});
            wreg(1, {16'h0, b});
            case (op)
                0: r = a + b;
                1: r = a - b;
                2: r = {1'b0, a & b};
                3: r = {1'b0, a | b};
                4: r = {1'b0, a ^ b};
                5: r = {a, 1'b0};
                6: r = {a[0], 1'b0, a[15:1]};
                default: r = {1'b0, a};
            endcase
            ef = {26'h0, op < 2 && (op == 1 ? a[15] != b[15] : a[15] == b[15]) && r[15] != a[15],
                1'b0, r[15], r[15:0] == 16'h0, 1'b0, r[16]};
            mk = op < 2 ? 32'h2d : (op > 4 ? 32'hd : 32'hc);
            xfer(1'b1, 12'h060, 32'(op));
            #1;
            chk("alu_flg", ef & mk, {21'h0, flag_word} & mk);
            bk[m[12][4]][0] = r[15:0];
            rreg(0);
        end
        // wide mode: pair operands and a 33-bit result
        for (int k = 0; k < 2; k++) begin
            ef = $random(seed);
            mk = $random(seed);
            xfer(1'b1, 12'h050, ef);
            xfer(1'b1, 12'h054, mk);
            rw = k == 1 ? {1'b0, ef} - {1'b0, mk} : {1'b0, ef} + {1'b0, mk};
            xfer(1'b1, 12'h060, 32'h8 | 32'(k));
            #1;
            d = {26'h0, (k == 1 ? ef[31] != mk[31] : ef[31] == mk[31]) && rw[31] != ef[31],
                1'b0, rw[31], rw[31:0] == 32'h0, 1'b0, rw[32]};
            chk("wide_flg", d & 32'h2d, {21'h0, flag_word} & 32'h2d);
            bk[m[12][4]][0] = rw[15:0];
            bk[m[12][4]][2] = rw[31:16];
            bk[m[12][4]][1] = mk[15:0];
            bk[m[12][4]][3] = mk[31:16];
            xfer(1'b0, 12'h050, 32'h0);
            chk("wide_res", rw[31:0], rd);
        end
        wreg(12, 32'h0);
        foreach (dec_a[j]) begin
            xfer(1'b1, 12'h064, {12'h0, dec_a[j]});
            #1;
            chk("region", {29'h0, dec_r[j]}, {29'h0, decode_region});
            xfer(1'b0, 12'h064, 32'h0);
            chk("dec_rd", {9'h0, dec_r[j], dec_a[j]}, rd);
        end
        foreach (bad[j]) begin
            xfer(1'b1, bad[j], 32'hffffffff);
            chk("err_w", 32'h1, {31'h0, err});
            xfer(1'b0, bad[j], 32'h0);
            chk("err_r", 32'h1, {31'h0, err});
            chk("bad_rd", 32'h0, rd);
        end
        for (int i = 0; i < 13; i++) rreg(i);
        @(posedge mclk);
        reset <= 1'b1;
        @(posedge mclk);
        reset <= 1'b0;
        bk = '{default: 16'h0};
        m = '{default: 32'h0};
        for (int i = 0; i < 13; i++) rreg(i);
        stop_test();
    end
endmodule
